// ==== common/lsic_pkg.sv ====
// constants and types for the link security and interrupt configuration block
// Behaviour
// (RULE_01) Verification on: check value compared once every sixteenth frame; off: never.
// (RULE_02) Link verification enable is config bit 7 and resets set, so config resets to 0x80.
// (RULE_03) Repeater enable bit 5 set makes the transmitter a repeater; clear stops it.
// (RULE_04) Encryption mode 4:3: 00 authenticated, 01 register, 10 always, 11 in-band per frame.
// (RULE_05) After reset the mode field is 11 if the repeater strap is set, else 00.
// (RULE_06) With qualify bit 1 clear, a detected receiver raises the detect interrupt at once.
// (RULE_07) With qualify bit 1 set, the detect interrupt also needs receive lock.
// (RULE_08) Enable bit 7 gates indirect access completion into the interrupt.
// (RULE_09) Enable bit 6 gates receiver detection into the interrupt.
// (RULE_10) Enable bit 5 gates forwarded downstream interrupt requests into the interrupt.
// (RULE_11) Global enable bit 0 gates the interrupt output; all interrupt enables reset to zero.
// (RULE_12) The global status flag is set whenever any enabled source is indicated.
// (RULE_13) Indirect access completion is reported at bit 7 of the status register at 0xC7.
// (RULE_14) Interrupt out is on when enabled and a source pends; reserved bits read zero.
package lsic_pkg;
   localparam logic [7:0] LSIC_CFG_OFF       = 8'hC2;
   localparam logic [7:0] LSIC_IEN_OFF       = 8'hC6;
   localparam logic [7:0] LSIC_ISR_OFF       = 8'hC7;
   localparam logic [7:0] LSIC_FRM_OFF       = 8'hD0; // frame-check status
   localparam logic [7:0] LSIC_CFG_RST       = 8'h80;
   localparam logic [7:0] LSIC_CFG_MASK      = 8'hBA; // writable config bits
   localparam logic [7:0] LSIC_IEN_RST       = 8'h00;
   localparam logic [7:0] LSIC_IEN_MASK      = 8'hE1;
   localparam logic [7:0] LSIC_SRC_MASK      = 8'hE0; // sticky source bits of status
   localparam logic [7:0] LSIC_ISR_MASK      = 8'hE1; // sources plus summary flag
   localparam int         LSIC_B_ELV         = 7;
   localparam int         LSIC_B_RPT         = 5;
   localparam int         LSIC_B_MODE_HI     = 4;
   localparam int         LSIC_B_MODE_LO     = 3;
   localparam int         LSIC_B_QUAL        = 1;
   localparam int         LSIC_B_IND         = 7;
   localparam int         LSIC_B_DET         = 6;
   localparam int         LSIC_B_DS          = 5;
   localparam int         LSIC_B_GLB         = 0;
   localparam int         LSIC_CHECK_PERIOD  = 16;
   typedef enum logic [1:0]
   {
      LSIC_ENC_AUTH   = 2'h0,
      LSIC_ENC_REG    = 2'h1,
      LSIC_ENC_ALWAYS = 2'h2,
      LSIC_ENC_INBAND = 2'h3
   } lsic_enc_mode_t;
endpackage : lsic_pkg

// ==== rtl/lsic_frame_check.sv ====
// frame counter that fires a link check value comparison every sixteenth frame
`timescale 1ns/10ps
module lsic_frame_check
   import lsic_pkg::*;
#(
   parameter int PERIOD = LSIC_CHECK_PERIOD
)
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic enable,
   input  wire logic frame_start,
   output logic      check_req_ff
);
   localparam int CW = $clog2(PERIOD);
   logic [CW-1:0] frame_cnt_ff;

   // count frames only while enabled so each enable starts a fresh period
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         frame_cnt_ff <= '0;
         check_req_ff <= 1'b0;
      end
      else
      begin
         check_req_ff <= 1'b0;
         if (!enable)
            frame_cnt_ff <= '0;
         else if (frame_start)
         begin
            frame_cnt_ff <= (frame_cnt_ff == CW'(PERIOD - 1)) ? '0 : CW'(frame_cnt_ff + 1'b1);
            check_req_ff <= (frame_cnt_ff == CW'(PERIOD - 1)); // [RULE_01]
         end
      end
   end

   a_check_period : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_01]
      check_req_ff |-> $past(enable) && $past(frame_start))
      else $error("check request without enabled frame start");
endmodule : lsic_frame_check

// ==== rtl/lsic_regs.sv ====
// apb register bank for link security config and interrupt control
`timescale 1ns/10ps
module lsic_regs
   import lsic_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        repeater_strap,
   input  wire logic        frame_start,
   input  wire logic        frame_check_match,
   input  wire logic        receiver_detected,
   input  wire logic        receiver_lock,
   input  wire logic        downstream_irq,
   input  wire logic        indirect_done,
   output logic             enhanced_link_verify_en,
   output logic             repeater_enable,
   output logic      [1:0]  encrypt_mode,
   output logic             encrypt_per_frame_inband,
   output logic             link_check_strobe,
   output logic             irq_out
);
   logic [7:0]     cfg_ff;
   logic [7:0]     ien_ff;
   logic [7:0]     isr_ff;
   logic [7:0]     nxt_isr;
   logic           strap_taken_ff;
   logic           inband_ff;
   logic           check_req;
   logic           check_fail_ff;
   logic [31:0]    prdata_ff;
   logic           pready_ff;
   logic           pslverr_ff;
   logic           irq_ff;
   logic           det_event;
   logic           access;
   logic [7:0]     reg_addr;

   // decode byte address to register offset; word aligned only
   function automatic logic known_addr(input logic [31:0] a);
      known_addr = (a[31:10] == '0) && (a[1:0] == 2'h0)
         && ((a[9:2] == LSIC_CFG_OFF) || (a[9:2] == LSIC_IEN_OFF)
         || (a[9:2] == LSIC_ISR_OFF) || (a[9:2] == LSIC_FRM_OFF));
   endfunction : known_addr

   assign access   = psel && penable && pready_ff;
   assign reg_addr = paddr[9:2];

   // detect qualification: bare detect or detect plus lock
   assign det_event = receiver_detected
      && (!cfg_ff[LSIC_B_QUAL] || receiver_lock); // [RULE_06] [RULE_07]

   // one wait state: pready rises in the second access cycle
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         pready_ff <= 1'b0;
      else
         pready_ff <= psel && penable && !pready_ff;
   end

   // config register; the strap is caught by a clocked process after reset
   // the in-band flag is kept beside the field so that its pin comes from a flop
   // and still changes on the same edge as the mode field
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_ff         <= LSIC_CFG_RST; // [RULE_02]
         inband_ff      <= 1'b0;
         strap_taken_ff <= 1'b0;
      end
      else if (!strap_taken_ff)
      begin
         strap_taken_ff <= 1'b1;
         cfg_ff[LSIC_B_MODE_HI:LSIC_B_MODE_LO] <= repeater_strap ?
            LSIC_ENC_INBAND : LSIC_ENC_AUTH; // [RULE_05]
         inband_ff      <= repeater_strap; // [RULE_05]
      end
      else if (access && pwrite && known_addr(paddr) && reg_addr == LSIC_CFG_OFF)
      begin
         cfg_ff    <= pwdata[7:0] & LSIC_CFG_MASK; // [RULE_03] [RULE_04]
         inband_ff <= pwdata[LSIC_B_MODE_HI:LSIC_B_MODE_LO] == LSIC_ENC_INBAND; // [RULE_04]
      end
   end

   // interrupt enable register
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         ien_ff <= LSIC_IEN_RST; // [RULE_11]
      else if (access && pwrite && known_addr(paddr) && reg_addr == LSIC_IEN_OFF)
         ien_ff <= pwdata[7:0] & LSIC_IEN_MASK;
   end

   // status: sticky sources cleared by reading, a new event beats the clear
   always_comb
   begin
      nxt_isr = isr_ff;
      if (access && !pwrite && known_addr(paddr) && reg_addr == LSIC_ISR_OFF)
         nxt_isr = 8'h00;
      if (indirect_done)
         nxt_isr[LSIC_B_IND] = 1'b1; // [RULE_13]
      if (det_event)
         nxt_isr[LSIC_B_DET] = 1'b1;
      if (downstream_irq)
         nxt_isr[LSIC_B_DS] = 1'b1;
      // summary uses the new source bits so it never lags them [RULE_08] [RULE_09] [RULE_10]
      nxt_isr[LSIC_B_GLB] = |(nxt_isr & ien_ff & LSIC_SRC_MASK); // [RULE_12]
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         isr_ff <= 8'h00;
      else
         isr_ff <= nxt_isr;
   end

   // periodic link check; a mismatch at a check is held for software
   lsic_frame_check #(.PERIOD(LSIC_CHECK_PERIOD)) u_frame_check
   (
      .clock        (clock),
      .rst_n        (rst_n),
      .enable       (cfg_ff[LSIC_B_ELV]),
      .frame_start  (frame_start),
      .check_req_ff (check_req)
   );

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         check_fail_ff <= 1'b0;
      else if (check_req && !frame_check_match)
         check_fail_ff <= 1'b1; // [RULE_01]
      else if (access && !pwrite && known_addr(paddr) && reg_addr == LSIC_FRM_OFF)
         check_fail_ff <= 1'b0;
   end

   // read data and error; reserved bits read zero
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
         if (psel && penable && !pready_ff)
         begin
            if (!known_addr(paddr))
               pslverr_ff <= 1'b1;
            else if (reg_addr == LSIC_CFG_OFF)
               prdata_ff[7:0] <= cfg_ff; // [RULE_14]
            else if (reg_addr == LSIC_IEN_OFF)
               prdata_ff[7:0] <= ien_ff;
            else if (reg_addr == LSIC_ISR_OFF)
               prdata_ff[7:0] <= isr_ff;
            else
               prdata_ff[0] <= check_fail_ff;
         end
      end
   end

   // interrupt pin, global enable gating the summary flag
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         irq_ff <= 1'b0;
      else
         irq_ff <= ien_ff[LSIC_B_GLB] && isr_ff[LSIC_B_GLB]; // [RULE_11] [RULE_14]
   end

   assign prdata                   = prdata_ff;
   assign pready                   = pready_ff;
   assign pslverr                  = pslverr_ff;
   assign irq_out                  = irq_ff;
   assign enhanced_link_verify_en  = cfg_ff[LSIC_B_ELV];
   assign repeater_enable          = cfg_ff[LSIC_B_RPT];
   assign encrypt_mode             = cfg_ff[LSIC_B_MODE_HI:LSIC_B_MODE_LO];
   assign encrypt_per_frame_inband = inband_ff;
   assign link_check_strobe        = check_req;

   // a detect that meets the qualify setting, seen on one edge
   sequence s_det_seen;
      receiver_detected && (!cfg_ff[LSIC_B_QUAL] || receiver_lock);
   endsequence

   // an access cycle still waiting for its answer
   sequence s_apb_wait;
      psel && penable && !pready_ff;
   endsequence

   // a settled config write; the strap cycle is excluded since it owns the field
   sequence s_cfg_write;
      strap_taken_ff && access && pwrite && known_addr(paddr) && reg_addr == LSIC_CFG_OFF;
   endsequence

   // a settled interrupt enable write
   sequence s_ien_write;
      access && pwrite && known_addr(paddr) && reg_addr == LSIC_IEN_OFF;
   endsequence

   // status capture and qualification
   a_det_unqual : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_06]
      s_det_seen |=> isr_ff[LSIC_B_DET])
      else $error("detect event not recorded");
   a_det_qual : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_07]
      $rose(isr_ff[LSIC_B_DET]) |-> $past(receiver_detected)
      && (!$past(cfg_ff[LSIC_B_QUAL]) || $past(receiver_lock)))
      else $error("detect status without qualified event");
   a_ind_flag : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_13]
      indirect_done |=> isr_ff[LSIC_B_IND])
      else $error("indirect completion lost");
   a_ds_flag : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_10]
      downstream_irq |=> isr_ff[LSIC_B_DS])
      else $error("downstream request lost");
   a_glb_flag : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_12]
      isr_ff[LSIC_B_GLB] == |(isr_ff & ien_ff & LSIC_SRC_MASK) || $changed(ien_ff))
      else $error("global flag wrong");

   // per-source gating into the summary flag
   a_gate_ind : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_08]
      indirect_done && ien_ff[LSIC_B_IND] && $stable(ien_ff) |=> isr_ff[LSIC_B_GLB])
      else $error("indirect enable ignored");
   a_gate_det : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_09]
      s_det_seen and ien_ff[LSIC_B_DET] && $stable(ien_ff) |=> isr_ff[LSIC_B_GLB])
      else $error("detect enable ignored");
   a_gate_ds : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_10]
      downstream_irq && ien_ff[LSIC_B_DS] && $stable(ien_ff) |=> isr_ff[LSIC_B_GLB])
      else $error("downstream enable ignored");

   // interrupt pin follows global enable and summary one edge later
   a_irq_gate : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_11]
      irq_out |-> $past(ien_ff[LSIC_B_GLB]) && $past(isr_ff[LSIC_B_GLB]))
      else $error("interrupt without global enable");
   a_irq_set : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_14]
      ien_ff[LSIC_B_GLB] && isr_ff[LSIC_B_GLB] |=> irq_out)
      else $error("enabled interrupt not driven");

   // configuration defaults and writes
   a_strap_mode : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_05]
      $rose(strap_taken_ff) |-> encrypt_mode
      == ($past(repeater_strap) ? LSIC_ENC_INBAND : LSIC_ENC_AUTH))
      else $error("strap mode default wrong");
   a_elv_reset : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_02]
      !strap_taken_ff |-> enhanced_link_verify_en)
      else $error("verify enable not set at reset");
   a_elv_write : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_02]
      s_cfg_write |=> enhanced_link_verify_en == $past(pwdata[LSIC_B_ELV]))
      else $error("verify enable not written");
   a_rpt_write : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_03]
      s_cfg_write |=> repeater_enable == $past(pwdata[LSIC_B_RPT]))
      else $error("repeater bit not written");
   a_mode_write : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_04]
      s_cfg_write |=> encrypt_mode == $past(pwdata[LSIC_B_MODE_HI:LSIC_B_MODE_LO]))
      else $error("mode field not written");
   a_inband_dec : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_04]
      encrypt_per_frame_inband == (encrypt_mode == LSIC_ENC_INBAND))
      else $error("in-band flag disagrees with mode");
   a_ien_write : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_11]
      s_ien_write |=> ien_ff == ($past(pwdata[7:0]) & LSIC_IEN_MASK))
      else $error("enable word not written");

   // periodic check result is held for software
   a_fail_hold : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_01]
      check_req && !frame_check_match |=> check_fail_ff)
      else $error("check mismatch not recorded");

   // reserved bits stay clear in storage and on the bus
   a_resv_zero : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_14]
      prdata[31:8] == '0)
      else $error("reserved read bits nonzero");
   a_cfg_resv : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_14]
      (cfg_ff & ~LSIC_CFG_MASK) == '0)
      else $error("reserved config bit set");
   a_ien_resv : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_14]
      (ien_ff & ~LSIC_IEN_MASK) == '0)
      else $error("reserved enable bit set");
   a_isr_resv : assert property (@(posedge clock) disable iff (!rst_n) // [RULE_14]
      (isr_ff & ~LSIC_ISR_MASK) == '0)
      else $error("reserved status bit set");

   // bus handshake: exactly one wait state, answer lasts one cycle
   a_apb_ready : assert property (@(posedge clock) disable iff (!rst_n)
      s_apb_wait |=> pready)
      else $error("access not answered after one wait");
   a_ready_pulse : assert property (@(posedge clock) disable iff (!rst_n)
      pready |=> !pready)
      else $error("ready held longer than one cycle");
   a_slverr_pair : assert property (@(posedge clock) disable iff (!rst_n)
      pslverr |-> pready)
      else $error("error without ready");
endmodule : lsic_regs

// ==== sim/lsic_rx_model.sv ====
// behavioural downstream receiver answering detect, lock and forwarded requests
`timescale 1ns/10ps
module lsic_rx_model
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic want_detect,
   input  wire logic want_lock,
   input  wire logic want_irq,
   output logic      receiver_detected,
   output logic      receiver_lock,
   output logic      downstream_irq
);
   // one cycle of lag, since status from across the link is never instant
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         receiver_detected <= 1'h0;
         receiver_lock     <= 1'h0;
         downstream_irq    <= 1'h0;
      end
      else
      begin
         receiver_detected <= want_detect;
         receiver_lock     <= want_lock;
         downstream_irq    <= want_irq;
      end
   end
endmodule : lsic_rx_model

// ==== sim/link_security_interrupt_config_bench.sv ====
// self-checking bench for the link security and interrupt configuration registers
`timescale 1ns/10ps
module link_security_interrupt_config_bench;
   import lsic_pkg::*;
   logic        clock, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata;
   logic        strap, frame_start, match, ind_done, det, lock, ds_irq;
   logic        want_det, want_lock, want_irq, elv, rpt, inband, strobe, irq_out;
   logic [1:0]  mode;
   int          n_fail, num_checks, n_strobe;

   // free-running 100 MHz clock
   initial
   begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end

   lsic_regs dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .repeater_strap(strap), .frame_start(frame_start),
      .frame_check_match(match), .receiver_detected(det), .receiver_lock(lock),
      .downstream_irq(ds_irq), .indirect_done(ind_done), .enhanced_link_verify_en(elv),
      .repeater_enable(rpt), .encrypt_mode(mode), .encrypt_per_frame_inband(inband),
      .link_check_strobe(strobe), .irq_out(irq_out));

   lsic_rx_model rx (.clock(clock), .rst_n(rst_n), .want_detect(want_det),
      .want_lock(want_lock), .want_irq(want_irq), .receiver_detected(det),
      .receiver_lock(lock), .downstream_irq(ds_irq));

   // strobe is a one-cycle pulse, so tally it on every edge
   always @(posedge clock)
      if (strobe === 1'h1)
         n_strobe++;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // one apb transfer; it waits for the answer and the watchdog guards a dead slave
   task automatic apb(input logic w, input logic [7:0] off, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clock);
      psel    <= 1'h1;
      pwrite  <= w;
      paddr   <= {22'h0, off, 2'h0};
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'h1;
      do
         @(posedge clock);
      while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task automatic wr(input logic [7:0] off, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'h1, off, d, r, e);
   endtask : wr

   task automatic rc(input logic [7:0] off, input logic [31:0] exp, input string nm);
      logic [31:0] r;
      logic        e;
      apb(1'h0, off, 32'h0, r, e);
      chk(nm, r, exp);
   endtask : rc

   task automatic do_reset(input logic s);
      rst_n <= 1'h0;
      strap <= s;
      repeat (16) @(posedge clock);
      rst_n <= 1'h1;
      repeat (2) @(posedge clock);
   endtask : do_reset

   task automatic t_reset;
      do_reset(1'h1);
      rc(LSIC_CFG_OFF, 32'h98, "cfg_strap");
      do_reset(1'h0);
      rc(LSIC_CFG_OFF, 32'h80, "cfg_rst");
      rc(LSIC_IEN_OFF, 32'h00, "ien_rst");
      $display("test reset done");
   endtask : t_reset

   task automatic frames(input int n);
      repeat (n)
      begin
         frame_start <= 1'h1;
         @(posedge clock);
         frame_start <= 1'h0;
         repeat (2) @(posedge clock);
      end
      repeat (3) @(posedge clock);
   endtask : frames

   task automatic t_frames;
      n_strobe = 0;
      frames(32);
      chk("strobes_on", n_strobe, 32'h2);
      rc(LSIC_FRM_OFF, 32'h1, "frm_fail");
      match <= 1'h1;
      n_strobe = 0;
      frames(16);
      chk("strobes_match", n_strobe, 32'h1);
      rc(LSIC_FRM_OFF, 32'h0, "frm_pass");
      match <= 1'h0;
      wr(LSIC_CFG_OFF, 32'h0);
      n_strobe = 0;
      frames(32);
      chk("strobes_off", n_strobe, 32'h0);
      $display("test frames done");
   endtask : t_frames

   task automatic t_modes;
      logic [31:0] r;
      logic        e;
      logic [7:0]  v;
      for (int m = 0; m < 4; m++)
      begin
         v = 8'(m << 3) | (m[0] ? 8'h20 : 8'h00);
         wr(LSIC_CFG_OFF, {24'h0, v});
         @(posedge clock);
         chk("mode", {30'h0, mode}, 32'(m));
         chk("inband", {31'h0, inband}, 32'(m == 3));
         chk("rpt", {31'h0, rpt}, {31'h0, v[5]});
         chk("elv_off", {31'h0, elv}, 32'h0);
      end
      wr(LSIC_CFG_OFF, 32'hFF);
      rc(LSIC_CFG_OFF, 32'hBA, "cfg_mask");
      wr(LSIC_IEN_OFF, 32'hFF);
      rc(LSIC_IEN_OFF, 32'hE1, "ien_mask");
      apb(1'h0, 8'hC3, 32'h0, r, e);
      chk("unmapped", {31'h0, e}, 32'h1);
      chk("unmapped_rd", r, 32'h0);
      wr(LSIC_IEN_OFF, 32'h0);
      $display("test modes done");
   endtask : t_modes

   // raise sources as det,lock,irq,done then judge the pin and the status word
   task automatic step(input logic [7:0] ien, input logic [7:0] cfg, input logic [3:0] src,
                       input logic irq_e, input logic [7:0] isr_e);
      wr(LSIC_IEN_OFF, {24'h0, ien});
      wr(LSIC_CFG_OFF, {24'h0, cfg});
      {want_det, want_lock, want_irq, ind_done} <= src;
      @(posedge clock);
      ind_done <= 1'h0;
      repeat (4) @(posedge clock);
      chk("irq_out", {31'h0, irq_out}, {31'h0, irq_e});
      {want_det, want_lock, want_irq} <= 3'h0;
      repeat (4) @(posedge clock);
      rc(LSIC_ISR_OFF, {24'h0, isr_e}, "isr");
   endtask : step

   task automatic t_irq;
      step(8'h81, 8'h00, 4'h1, 1'h1, 8'h81);
      step(8'h01, 8'h00, 4'h1, 1'h0, 8'h80);
      step(8'h41, 8'h00, 4'h8, 1'h1, 8'h41);
      step(8'h01, 8'h00, 4'h8, 1'h0, 8'h40);
      step(8'h41, 8'h02, 4'h8, 1'h0, 8'h00);
      step(8'h41, 8'h02, 4'hC, 1'h1, 8'h41);
      step(8'h21, 8'h00, 4'h2, 1'h1, 8'h21);
      step(8'h20, 8'h00, 4'h2, 1'h0, 8'h21);
      step(8'h01, 8'h00, 4'h2, 1'h0, 8'h20);
      $display("test irq done");
   endtask : t_irq

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up

   // the whole run needs several hundred cycles; far beyond that means a hang
   initial
   begin
      repeat (20000) @(posedge clock);
      n_fail++;
      wrap_up();
   end

   initial
   begin
      {rst_n, psel, penable, pwrite, strap, frame_start, match} = 7'h0;
      {ind_done, want_det, want_lock, want_irq} = 4'h0;
      paddr  = 32'h0;
      pwdata = 32'h0;
      t_reset();
      t_frames();
      t_modes();
      t_irq();
      wrap_up();
   end
endmodule : link_security_interrupt_config_bench
